// >>> design/sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ              = 125;
  localparam int unsigned BUS_W                = 16;
  localparam int unsigned STAT_W               = 8;
  localparam int unsigned RES_W_DEF            = 16;
  localparam int unsigned IDX_W                = 4;
  localparam int unsigned CNT_W                = 21;
  localparam int unsigned CONV_CNT_W           = 17;
  localparam int unsigned LEFT_W               = 5;
  localparam int unsigned FIFO_DEPTH           = 16;

  // ----------------------------------------------------------------
  // Timing, in clk cycles, conversions or nanoseconds
  // ----------------------------------------------------------------
  localparam int unsigned FULL_CAL_CYCLES_DEF  = 1443840;
  localparam int unsigned CONVS_PER_CAL_DEF    = 72192;
  localparam int unsigned SLICE_CYCLES         = 20;
  localparam int unsigned BIT_CYCLES           = 4;
  localparam int unsigned ACQ_TIME_NS          = 200;
  localparam int unsigned ACQ_CYCLES           = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OSC_IDLE_NS          = 400;
  localparam int unsigned OSC_IDLE_CYCLES      = (OSC_IDLE_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Synchronised pin vector positions
  // ----------------------------------------------------------------
  localparam int unsigned IN_W                 = 8;
  localparam int unsigned IN_HOLD              = 0;
  localparam int unsigned IN_CALREQ            = 1;
  localparam int unsigned IN_ILV_N             = 2;
  localparam int unsigned IN_CS_N              = 3;
  localparam int unsigned IN_RD_N              = 4;
  localparam int unsigned IN_WSEL              = 5;
  localparam int unsigned IN_MCLK              = 6;
  localparam int unsigned IN_COMP              = 7;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned ST_CAL_BUSY          = 0;
  localparam int unsigned ST_CALIBRATED        = 1;
  localparam int unsigned ST_ILV_ON            = 2;
  localparam int unsigned ST_INT_OSC           = 3;
  localparam int unsigned ST_EOC               = 4;
  localparam int unsigned ST_ACQ_READY         = 5;
  localparam int unsigned ST_FIFO_EMPTY        = 6;
  localparam int unsigned ST_ILV_WRAP          = 7;

  typedef enum logic [3:0] {
    SAC_CAL   = 4'h1,
    SAC_ACQ   = 4'h2,
    SAC_CONV  = 4'h4,
    SAC_SLICE = 4'h8
  } sac_state_t;

endpackage

// >>> design/sac_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full_w;
  logic             empty_w;
  logic             wr_en_w;
  logic             rd_en_w;

  // Extra pointer bit separates full from empty without a counter
  assign full_w    = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty_w   = (wr_q == rd_q);
  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign wr_en_w   = in_valid && !full_w;
  assign rd_en_w   = out_ready && !empty_w;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (wr_en_w) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (rd_en_w) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

// >>> design/sac_core.sv
`timescale 1ns/1ps
`default_nettype none
module sac_core #(
  parameter int unsigned RES_W           = sac_pkg::RES_W_DEF,
  parameter int unsigned FULL_CAL_CYCLES = sac_pkg::FULL_CAL_CYCLES_DEF,
  parameter int unsigned CONVS_PER_CAL   = sac_pkg::CONVS_PER_CAL_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       ser_clk,
  input  wire logic                       hold_n,
  input  wire logic                       cal_request,
  input  wire logic                       interleave_cal_n,
  input  wire logic                       cs_n,
  input  wire logic                       rd_n,
  input  wire logic                       word_select,
  input  wire logic                       master_clock_in,
  input  wire logic                       comp_hi,
  output logic                            acquire_done_n,
  output logic                            eoc_n,
  output logic                            track_hold,
  output logic      [RES_W-1:0]           dac_code,
  output logic      [sac_pkg::BUS_W-1:0]  parallel_data,
  output logic                            parallel_data_oe,
  output logic                            internal_osc_sel,
  output logic                            serial_bit_out,
  output logic                            serial_frame
);
  import sac_pkg::*;

  localparam logic [CNT_W-1:0]      CAL_LAST   = CNT_W'(FULL_CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0]      ACQ_LAST   = CNT_W'(ACQ_CYCLES - 1);
  localparam logic [CNT_W-1:0]      BIT_LAST   = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0]      SLICE_LAST = CNT_W'(SLICE_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_LAST  = CONV_CNT_W'(CONVS_PER_CAL - 1);
  localparam logic [CNT_W-1:0]      OSC_LAST   = CNT_W'(OSC_IDLE_CYCLES - 1);
  localparam logic [IDX_W-1:0]      IDX_TOP    = IDX_W'(RES_W - 1);
  localparam logic [LEFT_W-1:0]     LEFT_TOP   = LEFT_W'(RES_W - 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [IN_W-1:0] pin_raw_w;
  logic [IN_W-1:0] pin_meta_q;
  logic [IN_W-1:0] pin_sync_q;
  logic            hold_prev_q;

  assign pin_raw_w = {comp_hi, master_clock_in, word_select, rd_n, cs_n,
                      interleave_cal_n, cal_request, hold_n};

  always_ff @(posedge clk) begin
    pin_meta_q <= pin_raw_w;
    pin_sync_q <= pin_meta_q;
  end

  logic hold_s;
  logic cal_req_s;
  logic ilv_s;
  logic ws_s;
  logic mclk_s;
  logic comp_s;
  logic rd_act_w;
  logic hold_fall_w;

  assign hold_s      = pin_sync_q[IN_HOLD];
  assign cal_req_s   = pin_sync_q[IN_CALREQ];
  assign ilv_s       = !pin_sync_q[IN_ILV_N];
  assign ws_s        = pin_sync_q[IN_WSEL];
  assign mclk_s      = pin_sync_q[IN_MCLK];
  assign comp_s      = pin_sync_q[IN_COMP];
  assign rd_act_w    = !pin_sync_q[IN_CS_N] && !pin_sync_q[IN_RD_N];
  assign hold_fall_w = hold_prev_q && !hold_s;

  // ----------------------------------------------------------------
  // Sequencer: calibration, acquisition, conversion, slice
  // ----------------------------------------------------------------
  sac_state_t            state_q;
  sac_state_t            state_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic [IDX_W-1:0]      idx_q;
  logic [IDX_W-1:0]      idx_d;
  logic [RES_W-1:0]      sar_q;
  logic [RES_W-1:0]      sar_d;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [CONV_CNT_W-1:0] conv_cnt_d;
  logic [RES_W-1:0]      trial_w;
  logic [RES_W-1:0]      kept_w;
  logic                  acq_ok_w;
  logic                  start_w;
  logic                  conv_last_w;
  logic                  slice_end_w;
  logic                  wrap_w;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [RES_W-1:0]      fifo_out_data;
  logic                  take_w;

  assign trial_w     = RES_W'(1) << idx_q;
  assign kept_w      = comp_s ? sar_q : (sar_q & ~trial_w);
  assign acq_ok_w    = (state_q == SAC_ACQ) && (cnt_q == ACQ_LAST);
  // A full buffer stalls new conversions rather than dropping results
  assign start_w     = acq_ok_w && hold_fall_w && fifo_in_ready && !cal_req_s;
  assign conv_last_w = (state_q == SAC_CONV) && (cnt_q == BIT_LAST) && (idx_q == '0);
  assign slice_end_w = (state_q == SAC_SLICE) && (cnt_q == SLICE_LAST);
  assign wrap_w      = slice_end_w && (conv_cnt_q == CONV_LAST);

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    idx_d      = idx_q;
    sar_d      = sar_q;
    conv_cnt_d = conv_cnt_q;
    case (state_q)
      SAC_CAL: begin
        if (cnt_q == CAL_LAST) begin
          cnt_d = '0;
          if (!cal_req_s) begin
            state_d = SAC_ACQ;
          end
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      SAC_ACQ: begin
        if (cal_req_s) begin
          state_d = SAC_CAL;
          cnt_d   = '0;
        end else if (start_w) begin
          state_d = SAC_CONV;
          cnt_d   = '0;
          idx_d   = IDX_TOP;
          sar_d   = RES_W'(1) << IDX_TOP;
        end else if (!acq_ok_w) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      SAC_CONV: begin
        if (cnt_q != BIT_LAST) begin
          cnt_d = cnt_q + CNT_W'(1);
        end else begin
          cnt_d = '0;
          if (idx_q == '0) begin
            sar_d   = kept_w;
            state_d = ilv_s ? SAC_SLICE : SAC_ACQ;
          end else begin
            idx_d = idx_q - IDX_W'(1);
            sar_d = kept_w | (trial_w >> 1);
          end
        end
      end
      SAC_SLICE: begin
        if (slice_end_w) begin
          cnt_d      = '0;
          state_d    = SAC_ACQ;
          conv_cnt_d = wrap_w ? '0 : conv_cnt_q + CONV_CNT_W'(1);
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      default: begin
        state_d = SAC_CAL;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q    <= SAC_CAL;
      cnt_q      <= '0;
      idx_q      <= '0;
      sar_q      <= '0;
      conv_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      idx_q      <= idx_d;
      sar_q      <= sar_d;
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and handshake outputs
  // ----------------------------------------------------------------
  logic             acq_n_q;
  logic             eoc_n_q;
  logic             hold_q;
  logic             calibrated_q;
  logic             ilv_wrap_q;
  logic             rd_prev_q;
  logic             read_start_w;
  logic [RES_W-1:0] result_q;
  logic [CNT_W-1:0] osc_cnt_q;
  logic             int_osc_q;

  assign read_start_w = rd_act_w && !rd_prev_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_prev_q  <= 1'b1;
      acq_n_q      <= 1'b1;
      eoc_n_q      <= 1'b1;
      hold_q       <= 1'b0;
      calibrated_q <= 1'b0;
      ilv_wrap_q   <= 1'b0;
      rd_prev_q    <= 1'b0;
      result_q     <= '0;
    end else begin
      hold_prev_q <= hold_s;
      acq_n_q     <= !acq_ok_w;
      hold_q      <= (state_d == SAC_CONV);
      rd_prev_q   <= rd_act_w;
      if (conv_last_w) begin
        result_q <= kept_w;
      end
      // New result wins over a read in the same cycle
      eoc_n_q <= conv_last_w ? 1'b0 : (read_start_w ? 1'b1 : eoc_n_q);
      if ((state_q == SAC_CAL) && (cnt_q == CAL_LAST)) begin
        calibrated_q <= 1'b1;
      end
      ilv_wrap_q <= wrap_w || (ilv_wrap_q && !(read_start_w && !ws_s));
    end
  end

  // Master clock idle low for a while means the internal oscillator runs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_cnt_q <= '0;
      int_osc_q <= 1'b0;
    end else if (mclk_s) begin
      osc_cnt_q <= '0;
      int_osc_q <= 1'b0;
    end else if (osc_cnt_q == OSC_LAST) begin
      int_osc_q <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + CNT_W'(1);
    end
  end

  assign acquire_done_n   = acq_n_q;
  assign eoc_n            = eoc_n_q;
  assign track_hold       = hold_q;
  assign dac_code         = sar_q;
  assign internal_osc_sel = int_osc_q;

  // ----------------------------------------------------------------
  // Parallel readout
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] status_w;
  logic [BUS_W-1:0]  pdata_d;
  logic [BUS_W-1:0]  pdata_q;
  logic              poe_q;

  always_comb begin
    status_w                = '0;
    status_w[ST_CAL_BUSY]   = (state_q == SAC_CAL);
    status_w[ST_CALIBRATED] = calibrated_q;
    status_w[ST_ILV_ON]     = ilv_s;
    status_w[ST_INT_OSC]    = int_osc_q;
    status_w[ST_EOC]        = !eoc_n_q;
    status_w[ST_ACQ_READY]  = acq_ok_w;
    status_w[ST_FIFO_EMPTY] = !fifo_out_valid;
    status_w[ST_ILV_WRAP]   = ilv_wrap_q;
  end

  // Data follows the latest result every cycle, so a held read needs no strobing
  assign pdata_d = ws_s ? BUS_W'(result_q) : BUS_W'(status_w);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pdata_q <= '0;
      poe_q   <= 1'b0;
    end else begin
      pdata_q <= pdata_d;
      poe_q   <= rd_act_w;
    end
  end

  assign parallel_data    = pdata_q;
  assign parallel_data_oe = poe_q;

  // ----------------------------------------------------------------
  // Result buffer and crossing to the serial clock
  // ----------------------------------------------------------------
  sac_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (conv_last_w),
    .in_ready  (fifo_in_ready),
    .in_data   (kept_w),
    .out_valid (fifo_out_valid),
    .out_ready (take_w),
    .out_data  (fifo_out_data)
  );

  logic             busy_q;
  logic             req_tgl_q;
  logic [RES_W-1:0] xfer_q;
  logic             ack_meta_q;
  logic             ack_sync_q;
  logic             ack_tgl_q;

  assign take_w = fifo_out_valid && !busy_q;

  // Word is held stable until the acknowledge toggle returns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q     <= 1'b0;
      req_tgl_q  <= 1'b0;
      xfer_q     <= '0;
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_tgl_q;
      ack_sync_q <= ack_meta_q;
      if (take_w) begin
        xfer_q    <= fifo_out_data;
        req_tgl_q <= !req_tgl_q;
        busy_q    <= 1'b1;
      end else if (ack_sync_q == req_tgl_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter on the link clock
  // ----------------------------------------------------------------
  // Falling-edge launch gives the receiver half a period before its rising edge
  logic              s_rst_meta_q;
  logic              s_rst_n_q;
  logic              req_meta_q;
  logic              req_sync_q;
  logic [RES_W-1:0]  shift_q;
  logic [LEFT_W-1:0] left_q;
  logic              sbit_q;
  logic              sframe_q;
  logic              load_w;
  logic              load_msb_w;

  assign load_w     = (left_q == '0) && (req_sync_q != ack_tgl_q);
  assign load_msb_w = xfer_q[RES_W-1];

  always_ff @(negedge ser_clk) begin
    s_rst_meta_q <= reset_n;
    s_rst_n_q    <= s_rst_meta_q;
  end

  always_ff @(negedge ser_clk) begin
    if (!s_rst_n_q) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
      shift_q    <= '0;
      left_q     <= '0;
      sbit_q     <= 1'b0;
      sframe_q   <= 1'b0;
    end else begin
      req_meta_q <= req_tgl_q;
      req_sync_q <= req_meta_q;
      if (load_w) begin
        sbit_q    <= load_msb_w;
        shift_q   <= xfer_q << 1;
        left_q    <= LEFT_TOP;
        sframe_q  <= 1'b1;
        ack_tgl_q <= req_sync_q;
      end else if (left_q != '0) begin
        sbit_q   <= shift_q[RES_W-1];
        shift_q  <= shift_q << 1;
        left_q   <= left_q - LEFT_W'(1);
        sframe_q <= 1'b1;
      end else begin
        sframe_q <= 1'b0;
      end
    end
  end

  assign serial_bit_out = sbit_q;
  assign serial_frame   = sframe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_acq_done;
    @(posedge clk) disable iff (!reset_n)
    acq_ok_w |=> !acquire_done_n;
  endproperty
  a_acq_done: assert property (p_acq_done) else $error("acquire output not low when acquired");

  property p_hold_start;
    @(posedge clk) disable iff (!reset_n)
    start_w |=> (state_q == SAC_CONV) && track_hold && (idx_q == IDX_TOP);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("trigger edge did not start conversion");

  property p_cal_length;
    @(posedge clk) disable iff (!reset_n)
    ((state_q == SAC_ACQ) && $past(state_q == SAC_CAL)) |-> ($past(cnt_q) == CAL_LAST);
  endproperty
  a_cal_length: assert property (p_cal_length) else $error("calibration ended early");

  property p_burst_repeat;
    @(posedge clk) disable iff (!reset_n)
    ((state_q == SAC_CAL) && (cnt_q == CAL_LAST) && cal_req_s) |=> (state_q == SAC_CAL) && (cnt_q == '0);
  endproperty
  a_burst_repeat: assert property (p_burst_repeat) else $error("burst calibration did not repeat");

  property p_slice;
    @(posedge clk) disable iff (!reset_n)
    (conv_last_w && ilv_s) |=> (state_q == SAC_SLICE) ##(SLICE_CYCLES) (state_q == SAC_ACQ);
  endproperty
  a_slice: assert property (p_slice) else $error("calibration slice length wrong");

  property p_wrap;
    @(posedge clk) disable iff (!reset_n)
    wrap_w |=> (conv_cnt_q == '0) && ilv_wrap_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("interleave count did not wrap");

  property p_read_word;
    @(posedge clk) disable iff (!reset_n)
    (rd_act_w && ws_s) |=> (parallel_data == BUS_W'($past(result_q))) && parallel_data_oe;
  endproperty
  a_read_word: assert property (p_read_word) else $error("result word not presented");

  property p_read_status;
    @(posedge clk) disable iff (!reset_n)
    (rd_act_w && !ws_s) |=> (parallel_data[BUS_W-1:STAT_W] == '0);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read upper lines not low");

  property p_oe;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> (parallel_data_oe == $past(rd_act_w));
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");

  property p_eoc;
    @(posedge clk) disable iff (!reset_n)
    conv_last_w |=> !eoc_n ##1 (eoc_n == $past(read_start_w));
  endproperty
  a_eoc: assert property (p_eoc) else $error("end of conversion flag wrong");

  property p_osc;
    @(posedge clk) disable iff (!reset_n)
    ((osc_cnt_q == OSC_LAST) && !mclk_s) |=> internal_osc_sel;
  endproperty
  a_osc: assert property (p_osc) else $error("internal oscillator not selected");

  property p_msb_first;
    @(negedge ser_clk) disable iff (!s_rst_n_q)
    load_w |=> (serial_bit_out == $past(load_msb_w)) && serial_frame;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("serial word not MSB first");

endmodule
`default_nettype wire

// >>> tb/sac_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sac_rx #(
  parameter int unsigned W = 12
) (
  input  wire logic         ser_clk,
  input  wire logic         serial_bit_out,
  input  wire logic         serial_frame,
  output logic              word_valid,
  output logic      [W-1:0] word
);
  logic [W-1:0] shift_q;
  int           count_q = 0;
  initial word_valid = 1'b0;
  // Frames may run back to back, so words are cut by count, not by frame edges
  always @(posedge ser_clk) begin
    word_valid <= 1'b0;
    if (serial_frame === 1'b1) begin
      shift_q <= {shift_q[W-2:0], serial_bit_out};
      count_q <= (count_q == W - 1) ? 0 : count_q + 1;
      if (count_q == W - 1) begin
        word       <= {shift_q[W-2:0], serial_bit_out};
        word_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/sac_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module sac_core_test;
  import sac_pkg::*;
  localparam int unsigned RW = 12;
  localparam int unsigned FC = 64;
  localparam int unsigned CPC = 4;
  logic             clk, reset_n, ser_clk, hold_n, cal_request, interleave_cal_n, cs_n, rd_n;
  logic             word_select, master_clock_in, comp_hi, acquire_done_n, eoc_n, track_hold;
  logic             parallel_data_oe, internal_osc_sel, serial_bit_out, serial_frame, rx_valid;
  logic             loop, mclk_run, th_q;
  logic [RW-1:0]    dac_code, rx_word, ana;
  logic [BUS_W-1:0] parallel_data, d;
  logic [RW-1:0]    exp_q[$];
  int               errors = 0, compares = 0, cyc = 0, t_last = 0, gap = 0, gap0 = 0, nconv = 0;

  sac_core #(.RES_W(RW), .FULL_CAL_CYCLES(FC), .CONVS_PER_CAL(CPC)) u_sac_core (.clk, .reset_n, .ser_clk,
    .hold_n, .cal_request, .interleave_cal_n, .cs_n, .rd_n, .word_select, .master_clock_in, .comp_hi,
    .acquire_done_n, .eoc_n, .track_hold, .dac_code, .parallel_data, .parallel_data_oe, .internal_osc_sel,
    .serial_bit_out, .serial_frame);
  sac_rx #(.W(RW)) u_sac_rx (.ser_clk, .serial_bit_out, .serial_frame, .word_valid(rx_valid), .word(rx_word));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    ser_clk = 1'b0;
    #13;
    forever #32 ser_clk = ~ser_clk;
  end
  // Comparator model: a trial at or below the held input keeps its bit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    th_q <= track_hold;
    comp_hi <= ana >= dac_code;
    if (loop) hold_n <= acquire_done_n;
    if (mclk_run) master_clock_in <= ~master_clock_in;
    if (track_hold === 1'b1 && th_q === 1'b0) begin
      exp_q.push_back(ana);
      nconv <= nconv + 1;
      gap <= cyc - t_last;
      t_last <= cyc;
    end
  end
  always @(posedge ser_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_ser(rx_word, ~rx_word);
      else chk_ser(rx_word, exp_q.pop_front());
    end
  end

  task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ser(input logic [RW-1:0] got, input logic [RW-1:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic ws);
    @(posedge clk);
    word_select <= ws;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    // First driven word still carries flags that the read start clears
    repeat (3) @(posedge clk);
    #1 chk(parallel_data_oe, 1'b1);
    d = parallel_data;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(parallel_data_oe, 1'b0);
  endtask
  task automatic wait_acq(input int n);
    for (int i = 0; i < n && acquire_done_n !== 1'b0; i++) @(posedge clk);
    #1 chk(acquire_done_n, 1'b0);
  endtask
  task automatic wait_conv(input int n);
    for (int i = 0; i < 2000 && nconv < n; i++) @(posedge clk);
  endtask
  task automatic finish_test;
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h715C));
    {reset_n, cal_request, cs_n, rd_n, loop, th_q, ana, master_clock_in, comp_hi} = '0;
    {hold_n, interleave_cal_n, cs_n, rd_n, word_select, mclk_run} = 6'h3F;
    // Serial side syncs reset on its own clock, so hold through three link edges
    repeat (3) @(negedge ser_clk);
    #1 chk({acquire_done_n, eoc_n}, 2'h3);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (FC - 4) @(posedge clk);
    #1 chk(acquire_done_n, 1'b1);
    wait_acq(60);
    chk(internal_osc_sel, 1'b0);
    @(posedge clk);
    ana <= RW'($urandom);
    hold_n <= 1'b0;
    for (int i = 0; i < 200 && eoc_n !== 1'b0; i++) @(posedge clk);
    hold_n <= 1'b1;
    #1 chk(eoc_n, 1'b0);
    rd(1'b1);
    chk(d, BUS_W'(ana));
    chk(eoc_n, 1'b1);
    rd(1'b0);
    chk(d[15:8], 8'h00);
    chk(d[ST_CALIBRATED], 1'b1);
    @(posedge clk);
    ana <= RW'($urandom);
    {cs_n, rd_n, loop, word_select} <= 4'h3;
    wait_conv(nconv + 3);
    gap0 = gap;
    #1 chk(parallel_data, BUS_W'(ana));
    interleave_cal_n <= 1'b0;
    wait_conv(nconv + 2 * CPC + 2);
    chk(gap - gap0, SLICE_CYCLES);
    // Loopback stops one edge before hold_n is taken back, so only one process drives it
    loop <= 1'b0;
    @(posedge clk);
    {hold_n, cs_n, rd_n} <= 3'h7;
    repeat (150) @(posedge clk);
    rd(1'b0);
    chk(d[ST_ILV_WRAP], 1'b1);
    interleave_cal_n <= 1'b1;
    cal_request <= 1'b1;
    repeat (3 * FC) @(posedge clk);
    #1 chk(acquire_done_n, 1'b1);
    rd(1'b0);
    chk(d[ST_CAL_BUSY], 1'b1);
    cal_request <= 1'b0;
    wait_acq(2 * FC + 60);
    {mclk_run, master_clock_in} <= 2'h0;
    repeat (OSC_IDLE_CYCLES + 10) @(posedge clk);
    #1 chk(internal_osc_sel, 1'b1);
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk);
    chk(exp_q.size(), 0);
    finish_test;
  end
  // The sequence needs well under 10000 cycles; this cuts a hang
  initial begin
    #300000;
    errors++;
    finish_test;
  end
endmodule
`default_nettype wire
